// File: include/cfg_prog_pkg.sv
package cfg_prog_pkg;

    // ====================================================================
    // Memory geometry
    localparam int unsigned ADDR_W        = 17;
    localparam int unsigned DATA_W        = 8;
    localparam int unsigned PAGE_BITS     = 7;
    localparam int unsigned ADDR_BYTE_CNT = 3;
    localparam int unsigned FULL_ADDR_W   = ADDR_BYTE_CNT * DATA_W;

    // ====================================================================
    // Serial frame layout
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] LAST_BIT_IDX  = 4'h7;
    localparam int unsigned RW_BIT       = 0;
    localparam logic       RW_READ       = 1'b1;
    // Bus identity of the port; the value is arbitrary.
    localparam logic [6:0] DEV_ID        = 7'h5A;

    // ====================================================================
    // Pin sampling: index of each pin in the synchroniser vector
    localparam int unsigned PIN_SDA   = 0;
    localparam int unsigned PIN_SCL   = 1;
    localparam int unsigned PIN_MODE  = 2;
    localparam logic [2:0]  PIN_IDLE  = 3'h7;

    // ====================================================================
    // Timing
    localparam int unsigned CLK_FREQ_HZ             = 100_000_000;
    localparam int unsigned WRITE_CYCLE_TIME_MAX_MS = 20;
    localparam int unsigned WRITE_CYCLE_CYCLES      =
        (CLK_FREQ_HZ / 1000) * WRITE_CYCLE_TIME_MAX_MS;
    localparam int unsigned TIMER_W                 = 22;

    // ====================================================================
    // Protocol states and header phases
    typedef enum logic [4:0] {
        ST_IGNORE = 5'h01,
        ST_RECV   = 5'h02,
        ST_ACK    = 5'h04,
        ST_SEND   = 5'h08,
        ST_MACK   = 5'h10
    } state_e;

    typedef enum logic [4:0] {
        PH_DEV  = 5'h01,
        PH_ADR2 = 5'h02,
        PH_ADR1 = 5'h04,
        PH_ADR0 = 5'h08,
        PH_DATA = 5'h10
    } phase_e;

endpackage : cfg_prog_pkg

// File: hw/eeprom_mem.sv
module eeprom_mem #(
    parameter int unsigned AW = 17,
    parameter int unsigned DW = 8
) (
    input  wire logic          clk_i,
    input  wire logic          clk_en_i,
    input  wire logic          we_i,
    input  wire logic [AW-1:0] waddr_i,
    input  wire logic [DW-1:0] wdata_i,
    input  wire logic [AW-1:0] raddr_i,
    output logic      [DW-1:0] rdata_o
);

    logic [DW-1:0] mem [0:(2**AW)-1];

    always_ff @(posedge clk_i) begin
        if (clk_en_i) begin
            if (we_i) begin
                mem[waddr_i] <= wdata_i;
            end
            rdata_o <= mem[raddr_i];
        end
    end

endmodule : eeprom_mem

// File: hw/config_eeprom_serial_prog_port.sv
// What this block does
// - Port works only while the active-low mode select is low.
// - Data line is only pulled low or released; pull-up is external.
// - Data bits change only while the serial clock is low.
// - Start and stop are data edges while clock is high; both detected.
// - Any start drops the transfer and awaits a device address byte.
// - Stop after a write starts a timed cycle; lines ignored meanwhile.
// - Receiver pulls low in the ninth slot to accept a byte.
// - Header bytes go MSB first; data bytes go LSB first.
// - Read/write bit: one reads, zero writes.
// - Chip enable plays no part in bus selection.
// - Three address bytes, MSB first, each acknowledged.
// - Page write bumps only the low seven address bits, wrapping.
// - Write: start, header, three address bytes, data bytes, stop.
// - Nothing is acknowledged during the write cycle.
// - Address counter holds last address plus one while mode is held.
// - Write ending on a page's last byte points counter to next page.
// - Acknowledged read header sends the byte at the counter.
// - Programmer acknowledge makes the device send the next byte.
// - Sequential read past the last address wraps to address zero.
module config_eeprom_serial_prog_port #(
    parameter int unsigned WRITE_CYCLES = cfg_prog_pkg::WRITE_CYCLE_CYCLES
) (
    input  wire logic MCLK_I,
    input  wire logic RST_I,
    input  wire logic CLK_EN_I,
    input  wire logic PROGRAM_MODE_SELECT_N_I,
    input  wire logic PROG_SERIAL_CLOCK_I,
    input  wire logic PROG_SERIAL_DATA_LINE_I,
    output logic      PROG_SERIAL_DATA_LINE_O,
    output logic      PROG_SERIAL_DATA_LINE_OE_O,
    output logic      WRITE_BUSY_O
);

    // ====================================================================
    // Pin synchronisers and event detection
    logic [2:0] pin_s1;
    logic [2:0] pin_s2;
    logic [2:0] pin_s3;
    logic [2:0] pin_f;
    logic [2:0] pin_p;

    // A pin level is taken over only once the second and third stages agree.
    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            pin_s1 <= cfg_prog_pkg::PIN_IDLE;
            pin_s2 <= cfg_prog_pkg::PIN_IDLE;
            pin_s3 <= cfg_prog_pkg::PIN_IDLE;
            pin_f  <= cfg_prog_pkg::PIN_IDLE;
            pin_p  <= cfg_prog_pkg::PIN_IDLE;
        end else if (CLK_EN_I) begin
            pin_s1 <= {PROGRAM_MODE_SELECT_N_I, PROG_SERIAL_CLOCK_I, PROG_SERIAL_DATA_LINE_I};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            pin_f  <= ((pin_s2 ~^ pin_s3) & pin_s3) | ((pin_s2 ^ pin_s3) & pin_f);
            pin_p  <= pin_f;
        end
    end

    logic sda_f;
    logic scl_f;
    logic mode_n_f;
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;

    assign sda_f    = pin_f[cfg_prog_pkg::PIN_SDA];
    assign scl_f    = pin_f[cfg_prog_pkg::PIN_SCL];
    assign mode_n_f = pin_f[cfg_prog_pkg::PIN_MODE];
    assign scl_rise = scl_f & ~pin_p[cfg_prog_pkg::PIN_SCL];
    assign scl_fall = ~scl_f & pin_p[cfg_prog_pkg::PIN_SCL];
    // Data edges while the clock stays high frame a message.
    assign start_ev = scl_f & pin_p[cfg_prog_pkg::PIN_SCL]
                      & ~sda_f & pin_p[cfg_prog_pkg::PIN_SDA];
    assign stop_ev  = scl_f & pin_p[cfg_prog_pkg::PIN_SCL]
                      & sda_f & ~pin_p[cfg_prog_pkg::PIN_SDA];

    // ====================================================================
    // Internally timed write cycle
    logic                             busy;
    logic [cfg_prog_pkg::TIMER_W-1:0] wr_timer;
    logic                             wrote;

    localparam logic [cfg_prog_pkg::TIMER_W-1:0] WR_LAST =
        cfg_prog_pkg::TIMER_W'(WRITE_CYCLES - 1);

    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            busy     <= 1'b0;
            wr_timer <= '0;
        end else if (CLK_EN_I) begin
            if (busy) begin
                if (wr_timer == WR_LAST) begin
                    busy     <= 1'b0;
                    wr_timer <= '0;
                end else begin
                    wr_timer <= wr_timer + 1'b1;
                end
            end else if (stop_ev && wrote && !mode_n_f) begin
                busy <= 1'b1;
            end
        end
    end

    assign WRITE_BUSY_O = busy;

    // ====================================================================
    // Protocol engine
    cfg_prog_pkg::state_e            state;
    cfg_prog_pkg::phase_e            phase;
    logic [3:0]                      bitcnt;
    logic [7:0]                      rx;
    logic [7:0]                      adr_hi;
    logic [7:0]                      adr_mid;
    logic [7:0]                      tx_shift;
    logic                            read_op;
    logic                            mack;
    logic                            drive_low;
    logic [cfg_prog_pkg::ADDR_W-1:0] cnt;
    logic [cfg_prog_pkg::ADDR_W-1:0] wr_ptr;
    logic                            mem_we;
    logic [cfg_prog_pkg::ADDR_W-1:0] mem_waddr;
    logic [7:0]                      mem_wdata;
    logic [7:0]                      mem_rdata;
    logic [cfg_prog_pkg::FULL_ADDR_W-1:0] full_addr;
    logic [cfg_prog_pkg::ADDR_W-1:0] next_wr_ptr;

    assign full_addr   = {adr_hi, adr_mid, rx};
    // Only the in-page bits advance during a page write.
    assign next_wr_ptr = {wr_ptr[cfg_prog_pkg::ADDR_W-1:cfg_prog_pkg::PAGE_BITS],
                          wr_ptr[cfg_prog_pkg::PAGE_BITS-1:0] + 1'b1};

    always_ff @(posedge MCLK_I or posedge RST_I) begin
        if (RST_I) begin
            state     <= cfg_prog_pkg::ST_IGNORE;
            phase     <= cfg_prog_pkg::PH_DEV;
            bitcnt    <= 4'h0;
            rx        <= 8'h00;
            adr_hi    <= 8'h00;
            adr_mid   <= 8'h00;
            tx_shift  <= 8'h00;
            read_op   <= 1'b0;
            mack      <= 1'b0;
            drive_low <= 1'b0;
            cnt       <= '0;
            wr_ptr    <= '0;
            wrote     <= 1'b0;
            mem_we    <= 1'b0;
            mem_waddr <= '0;
            mem_wdata <= 8'h00;
        end else if (CLK_EN_I) begin
            mem_we <= 1'b0;
            if (mode_n_f) begin
                // Leaving programming mode drops the port and the counter.
                state     <= cfg_prog_pkg::ST_IGNORE;
                drive_low <= 1'b0;
                wrote     <= 1'b0;
                cnt       <= '0;
                wr_ptr    <= '0;
            end else if (busy) begin
                state     <= cfg_prog_pkg::ST_IGNORE;
                drive_low <= 1'b0;
            end else if (start_ev) begin
                state     <= cfg_prog_pkg::ST_RECV;
                phase     <= cfg_prog_pkg::PH_DEV;
                bitcnt    <= 4'h0;
                read_op   <= 1'b0;
                drive_low <= 1'b0;
                wrote     <= 1'b0;
            end else if (stop_ev) begin
                state     <= cfg_prog_pkg::ST_IGNORE;
                drive_low <= 1'b0;
                wrote     <= 1'b0;
            end else begin
                case (state)
                    cfg_prog_pkg::ST_RECV: begin
                        if (scl_rise && bitcnt != cfg_prog_pkg::BITS_PER_BYTE) begin
                            if (phase == cfg_prog_pkg::PH_DATA) begin
                                rx <= {sda_f, rx[7:1]};
                            end else begin
                                rx <= {rx[6:0], sda_f};
                            end
                            bitcnt <= bitcnt + 4'h1;
                        end else if (scl_fall && bitcnt == cfg_prog_pkg::BITS_PER_BYTE) begin
                            bitcnt    <= 4'h0;
                            state     <= cfg_prog_pkg::ST_ACK;
                            drive_low <= 1'b1;
                            case (phase)
                                cfg_prog_pkg::PH_DEV: begin
                                    // Selection looks at the identity alone.
                                    if (rx[7:1] == cfg_prog_pkg::DEV_ID) begin
                                        read_op <= (rx[cfg_prog_pkg::RW_BIT]
                                                    == cfg_prog_pkg::RW_READ);
                                        phase   <= cfg_prog_pkg::PH_ADR2;
                                    end else begin
                                        state     <= cfg_prog_pkg::ST_IGNORE;
                                        drive_low <= 1'b0;
                                    end
                                end
                                cfg_prog_pkg::PH_ADR2: begin
                                    adr_hi <= rx;
                                    phase  <= cfg_prog_pkg::PH_ADR1;
                                end
                                cfg_prog_pkg::PH_ADR1: begin
                                    adr_mid <= rx;
                                    phase   <= cfg_prog_pkg::PH_ADR0;
                                end
                                cfg_prog_pkg::PH_ADR0: begin
                                    wr_ptr <= full_addr[cfg_prog_pkg::ADDR_W-1:0];
                                    cnt    <= full_addr[cfg_prog_pkg::ADDR_W-1:0];
                                    phase  <= cfg_prog_pkg::PH_DATA;
                                end
                                cfg_prog_pkg::PH_DATA: begin
                                    mem_we    <= 1'b1;
                                    mem_waddr <= wr_ptr;
                                    mem_wdata <= rx;
                                    wr_ptr    <= next_wr_ptr;
                                    cnt       <= wr_ptr + 1'b1;
                                    wrote     <= 1'b1;
                                end
                                default: begin
                                    state     <= cfg_prog_pkg::ST_IGNORE;
                                    drive_low <= 1'b0;
                                end
                            endcase
                        end
                    end
                    cfg_prog_pkg::ST_ACK: begin
                        // The acknowledge is held over the whole ninth clock.
                        if (scl_fall) begin
                            if (read_op) begin
                                state     <= cfg_prog_pkg::ST_SEND;
                                tx_shift  <= mem_rdata;
                                drive_low <= ~mem_rdata[0];
                                bitcnt    <= 4'h0;
                            end else begin
                                state     <= cfg_prog_pkg::ST_RECV;
                                drive_low <= 1'b0;
                            end
                        end
                    end
                    cfg_prog_pkg::ST_SEND: begin
                        if (scl_fall) begin
                            if (bitcnt == cfg_prog_pkg::LAST_BIT_IDX) begin
                                state     <= cfg_prog_pkg::ST_MACK;
                                drive_low <= 1'b0;
                                bitcnt    <= 4'h0;
                                cnt       <= cnt + 1'b1;
                            end else begin
                                tx_shift  <= {1'b0, tx_shift[7:1]};
                                drive_low <= ~tx_shift[1];
                                bitcnt    <= bitcnt + 4'h1;
                            end
                        end
                    end
                    cfg_prog_pkg::ST_MACK: begin
                        if (scl_rise) begin
                            mack <= ~sda_f;
                        end else if (scl_fall) begin
                            if (mack) begin
                                state     <= cfg_prog_pkg::ST_SEND;
                                tx_shift  <= mem_rdata;
                                drive_low <= ~mem_rdata[0];
                            end else begin
                                state <= cfg_prog_pkg::ST_IGNORE;
                            end
                        end
                    end
                    cfg_prog_pkg::ST_IGNORE: begin
                        drive_low <= 1'b0;
                    end
                    default: begin
                        state     <= cfg_prog_pkg::ST_IGNORE;
                        drive_low <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Open-collector pin: the driven level is always low.
    assign PROG_SERIAL_DATA_LINE_O    = 1'b0;
    assign PROG_SERIAL_DATA_LINE_OE_O = drive_low;

    // ====================================================================
    // Array storage
    eeprom_mem #(
        .AW (cfg_prog_pkg::ADDR_W),
        .DW (cfg_prog_pkg::DATA_W)
    ) u_mem (
        .clk_i    (MCLK_I),
        .clk_en_i (CLK_EN_I),
        .we_i     (mem_we),
        .waddr_i  (mem_waddr),
        .wdata_i  (mem_wdata),
        .raddr_i  (cnt),
        .rdata_o  (mem_rdata)
    );

    // ====================================================================
    // Assertions
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (RST_I);

    sequence seq_byte_end;
        CLK_EN_I && !mode_n_f && !busy && !start_ev && !stop_ev
        && state == cfg_prog_pkg::ST_RECV && scl_fall
        && bitcnt == cfg_prog_pkg::BITS_PER_BYTE;
    endsequence

    sequence seq_data_byte;
        seq_byte_end ##0 phase == cfg_prog_pkg::PH_DATA;
    endsequence

    AST_MODE_OFF_RELEASED: assert property (
        mode_n_f && $past(mode_n_f) && $past(CLK_EN_I) |-> !drive_low)
        else $error("data line driven outside programming mode");

    AST_BUSY_SILENT: assert property (
        busy && $past(busy) |-> !drive_low && state == cfg_prog_pkg::ST_IGNORE)
        else $error("port active during write cycle");

    AST_STOP_LAUNCH: assert property (
        CLK_EN_I && stop_ev && wrote && !mode_n_f && !busy |=> busy [*8])
        else $error("write cycle not launched by stop");

    AST_START_IDLE: assert property (
        CLK_EN_I && start_ev && !mode_n_f && !busy |=>
        state == cfg_prog_pkg::ST_RECV && phase == cfg_prog_pkg::PH_DEV && bitcnt == 4'h0)
        else $error("start did not return to header reception");

    AST_ID_MISMATCH: assert property (
        seq_byte_end ##0 (phase == cfg_prog_pkg::PH_DEV && rx[7:1] != cfg_prog_pkg::DEV_ID)
        |=> !drive_low && state == cfg_prog_pkg::ST_IGNORE)
        else $error("foreign header acknowledged");

    AST_ACK_DRIVEN: assert property (
        seq_byte_end ##0 phase != cfg_prog_pkg::PH_DEV |=> drive_low)
        else $error("received byte not acknowledged");

    AST_PAGE_WRAP: assert property (
        seq_data_byte |=>
        wr_ptr[cfg_prog_pkg::ADDR_W-1:cfg_prog_pkg::PAGE_BITS]
            == $past(wr_ptr[cfg_prog_pkg::ADDR_W-1:cfg_prog_pkg::PAGE_BITS])
        && wr_ptr[cfg_prog_pkg::PAGE_BITS-1:0]
            == $past(wr_ptr[cfg_prog_pkg::PAGE_BITS-1:0]) + 7'h01)
        else $error("page write pointer left its page");

    AST_CNT_NEXT_PAGE: assert property (
        seq_data_byte |=> cnt == $past(wr_ptr) + 17'h00001 && mem_we)
        else $error("read counter not last written plus one");

    AST_SEND_BIT: assert property (
        state == cfg_prog_pkg::ST_SEND |-> drive_low == !tx_shift[0])
        else $error("transmitted bit differs from shift register");

    AST_READ_WRAP: assert property (
        CLK_EN_I && !mode_n_f && !busy && !start_ev && !stop_ev
        && state == cfg_prog_pkg::ST_SEND && scl_fall
        && bitcnt == cfg_prog_pkg::LAST_BIT_IDX
        |=> cnt == $past(cnt) + 17'h00001 && state == cfg_prog_pkg::ST_MACK)
        else $error("read counter not advanced after byte");

    AST_NO_DRIVE_IN_RX: assert property (
        state == cfg_prog_pkg::ST_RECV && $past(state) == cfg_prog_pkg::ST_RECV
        |-> !drive_low)
        else $error("line pulled while receiving");

endmodule : config_eeprom_serial_prog_port

// File: testbench/serial_programmer_model.sv
module serial_programmer_model (
    input  wire logic lclk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      pull_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        scl_o = 1'b1;
        pull_o = 1'b0;
    end

    task automatic half();
        repeat (3) @(negedge lclk_i);
    endtask : half

    // The clock rises only once data has settled, and stands still between frames.
    task automatic bit_x(input logic b, output logic r);
        pull_o = ~b;
        half();
        scl_o = 1'b1;
        half();
        r = sda_i;
        scl_o = 1'b0;
        half();
    endtask : bit_x

    task automatic start();
        pull_o = 1'b0;
        half();
        scl_o = 1'b1;
        half();
        pull_o = 1'b1;
        half();
        scl_o = 1'b0;
        half();
    endtask : start

    task automatic stop();
        pull_o = 1'b1;
        half();
        scl_o = 1'b1;
        half();
        pull_o = 1'b0;
        half();
    endtask : stop

    task automatic put_byte(input logic [7:0] v, input logic lsb, output logic ack);
        logic r;
        for (int i = 0; i < 8; i++) begin
            bit_x(lsb ? v[i] : v[7-i], r);
        end
        bit_x(1'b1, r);
        ack = ~r;
    endtask : put_byte

    task automatic get_byte(input logic ack, output logic [7:0] v);
        logic r;
        for (int i = 0; i < 8; i++) begin
            bit_x(1'b1, r);
            v[i] = r;
        end
        bit_x(~ack, r);
    endtask : get_byte
endmodule : serial_programmer_model

// File: testbench/config_eeprom_serial_prog_port_tb.sv
module config_eeprom_serial_prog_port_tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int unsigned WCYC       = 1000;
    localparam int unsigned PAGE_BYTES = 128;
    logic mclk = 1'b0;
    logic lclk = 1'b0;
    logic rst = 1'b1;
    logic mode_n = 1'b0;
    logic scl;
    logic pull;
    logic oe;
    logic dout;
    logic busy;
    wire  sda = ~((oe & ~dout) | pull);
    int   num_errors = 0;
    int   samples_checked = 0;

    always #5 mclk = ~mclk;
    initial begin
        #7;
        forever #15 lclk = ~lclk;
    end

    config_eeprom_serial_prog_port #(.WRITE_CYCLES(WCYC)) dut_u (
        .MCLK_I(mclk), .RST_I(rst), .CLK_EN_I(1'b1), .PROGRAM_MODE_SELECT_N_I(mode_n),
        .PROG_SERIAL_CLOCK_I(scl), .PROG_SERIAL_DATA_LINE_I(sda),
        .PROG_SERIAL_DATA_LINE_O(dout), .PROG_SERIAL_DATA_LINE_OE_O(oe), .WRITE_BUSY_O(busy));

    serial_programmer_model prog_u (.lclk_i(lclk), .sda_i(sda), .scl_o(scl), .pull_o(pull));

    // ====================================================================
    // Checking and closing
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic summarize();
        $display("errors %0d, comparisons %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : summarize

    // ====================================================================
    // Transfers
    task automatic header(input logic rw, input logic exp);
        logic a;
        prog_u.start();
        prog_u.put_byte({cfg_prog_pkg::DEV_ID, rw}, 1'b0, a);
        check({7'h00, a}, {7'h00, exp});
    endtask : header

    task automatic addr(input logic [16:0] a);
        logic        k;
        logic [23:0] f;
        f = {7'h00, a};
        for (int i = 0; i < 3; i++) begin
            prog_u.put_byte(f[23-8*i -: 8], 1'b0, k);
            check({7'h00, k}, 8'h01);
        end
    endtask : addr

    // A whole page is written; byte i carries d0 plus i.
    task automatic wr(input logic [16:0] a, input logic [7:0] d0);
        logic k;
        header(1'b0, 1'b1);
        addr(a);
        for (int i = 0; i < PAGE_BYTES; i++) begin
            prog_u.put_byte(d0 + 8'(i), 1'b1, k);
            check({7'h00, k}, 8'h01);
        end
        prog_u.stop();
        check({7'h00, busy}, 8'h01);
        header(1'b0, 1'b0);
        for (int i = 0; i < 2 * WCYC && busy; i++) begin
            @(negedge mclk);
        end
        check({7'h00, busy}, 8'h00);
    endtask : wr

    task automatic rd(input logic [16:0] a, input logic rnd, input logic [7:0] e0,
                      input logic [7:0] e1, input int n);
        logic [7:0] v;
        if (rnd) begin
            header(1'b0, 1'b1);
            addr(a);
        end
        header(1'b1, 1'b1);
        prog_u.get_byte(n > 1, v);
        check(v, e0);
        if (n > 1) begin
            prog_u.get_byte(1'b0, v);
            check(v, e1);
        end
        prog_u.stop();
    endtask : rd

    // A foreign header and a header outside programming mode are both refused.
    task automatic refuse();
        logic k;
        prog_u.start();
        prog_u.put_byte({~cfg_prog_pkg::DEV_ID, 1'b1}, 1'b0, k);
        check({7'h00, k}, 8'h00);
        prog_u.stop();
        @(negedge mclk) mode_n = 1'b1;
        repeat (10) @(negedge mclk);
        header(1'b1, 1'b0);
        prog_u.stop();
        @(negedge mclk) mode_n = 1'b0;
        repeat (10) @(negedge mclk);
    endtask : refuse

    initial begin
        #900_000;
        num_errors++;
        summarize();
    end

    initial begin
        repeat (3) @(posedge mclk);
        @(negedge mclk) rst = 1'b0;
        repeat (8) @(negedge mclk);
        wr(17'h0007F, 8'h3C);
        wr(17'h1FF80, 8'hA7);
        rd(17'h00000, 1'b0, 8'h3D, 8'h3E, 2);
        rd(17'h1FFFF, 1'b1, 8'h26, 8'h3D, 2);
        refuse();
        rd(17'h00000, 1'b0, 8'h3D, 8'h00, 1);
        summarize();
    end
endmodule : config_eeprom_serial_prog_port_tb
